// file: verilog/ealu_pkg.sv
// Shared constants, operation codes and flag positions for the 8-bit ALU
package ealu_pkg;
  // ===========================================================
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FLAG_W = 6;

  // ===========================================================
  // Status flag positions within the flag vector
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;

  // ===========================================================
  // Cycle counts
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_DOUBLE = 2'h2;

  // ===========================================================
  // Constants
  localparam logic [7:0]  ALL_ONES  = 8'hff;
  localparam logic [7:0]  ALL_ZERO  = 8'h00;
  localparam logic [7:0]  ONE_STEP  = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [5:0]  FLAGS_RST = 6'h00;

  // ===========================================================
  // Operation codes
  typedef enum logic [4:0] {
    EALU_ADD, EALU_ADD_CARRY, EALU_WORD_PLUS_IMMEDIATE,
    EALU_SUB, EALU_MINUS_IMMEDIATE, EALU_MINUS_WITH_BORROW,
    EALU_MINUS_IMMEDIATE_BORROW, EALU_WORD_MINUS_IMMEDIATE,
    EALU_AND, EALU_IMMEDIATE_CONJUNCTION, EALU_OR, EALU_IMMEDIATE_UNION,
    EALU_BITWISE_EXCLUSIVE_UNION, EALU_ONES_INVERT,
    EALU_TWOS_INVERT_PLUS_ONE, EALU_BIT_SET_IMMEDIATE,
    EALU_BIT_CLEAR_IMMEDIATE, EALU_PLUS_ONE_STEP, EALU_MINUS_ONE_STEP,
    EALU_ZERO_SIGN_CHECK, EALU_ZERO_REGISTER, EALU_ALL_ONES_LOAD,
    EALU_UNSIGNED_PRODUCT, EALU_SIGNED_PRODUCT, EALU_MIXED_SIGN_PRODUCT,
    EALU_FRACTION_UNSIGNED_PRODUCT, EALU_FRACTION_SIGNED_PRODUCT,
    EALU_FRACTION_MIXED_PRODUCT
  } ealu_op_t;
endpackage

// file: verilog/ealu_adder.sv
// Generic 8-bit add/subtract slice with carry, half carry and overflow
`timescale 1ns/100ps
module ealu_adder #(
  parameter int unsigned W = 8
) (
  // Operands
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  input  wire logic         cin_i,
  input  wire logic         sub_i,
  // Results
  output logic      [W-1:0] sum_o,
  output logic              cout_o,
  output logic              half_o,
  output logic              ovf_o
);
  // ===========================================================
  // Subtract is a + ~b + ~borrow; carry out is inverted to a borrow
  wire logic [W-1:0] b_eff  = sub_i ? ~b_i : b_i;
  wire logic         c_eff  = sub_i ? ~cin_i : cin_i;
  wire logic [W:0]   full   = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
  wire logic [4:0]   nibble = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]}
                              + {4'h0, c_eff};
  assign sum_o  = full[W-1:0];
  assign cout_o = sub_i ? ~full[W] : full[W];
  assign half_o = sub_i ? ~nibble[4] : nibble[4];
  assign ovf_o  = (a_i[W-1] == b_eff[W-1]) && (sum_o[W-1] != a_i[W-1]);
endmodule

// file: verilog/ealu_mult.sv
// 8x8 multiplier with signed, unsigned, mixed and fractional forms
`timescale 1ns/100ps
module ealu_mult (
  // Operands and mode
  input  wire logic [7:0]  a_i,
  input  wire logic [7:0]  b_i,
  input  wire logic        a_signed_i,
  input  wire logic        b_signed_i,
  input  wire logic        frac_i,
  // Product and carry
  output logic      [15:0] prod_o,
  output logic             carry_o
);
  // ===========================================================
  // Sign extend to 17 bits so one signed multiply covers all forms
  wire logic signed [16:0] ax  = {{9{a_signed_i & a_i[7]}}, a_i};
  wire logic signed [16:0] bx  = {{9{b_signed_i & b_i[7]}}, b_i};
  wire logic signed [33:0] raw = ax * bx;
  wire logic [15:0]        p16 = raw[15:0];
  // Carry is bit 15 before the fractional shift
  assign carry_o = p16[15];
  assign prod_o  = frac_i ? {p16[14:0], 1'b0} : p16;
endmodule

// file: verilog/ealu_core.sv
// 8-bit arithmetic and logic datapath with status flags and cycle timing
//
// Operation
// - Add registers, optional carry, flags, one cycle
// - Word plus immediate with flags, two cycles
// - Subtract registers into destination, one cycle
// - Subtract immediate from destination, one cycle
// - Subtract register and carry, one cycle
// - Subtract immediate and carry, one cycle
// - Word minus immediate over two cycles
// - AND with register or immediate, Z N V
// - OR, XOR register, OR immediate, Z N V
// - Set bits ORs immediate mask, Z N V
// - Clear bits ANDs inverted mask, Z N V
// - Test ANDs register with itself, unchanged
// - Products into R1:R0, Z C, two cycles
// - Fractional products shifted left one, two cycles
`timescale 1ns/100ps
module ealu_core (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Request from the decoder
  input  wire logic                  start_i,
  input  wire ealu_pkg::ealu_op_t    op_i,
  input  wire logic [7:0]            rd_i,
  input  wire logic [7:0]            rdh_i,
  input  wire logic [7:0]            rr_i,
  input  wire logic [7:0]            imm_i,
  // Result to the register file
  output logic                       done_o,
  output logic                       busy_o,
  output logic                       wr_en_o,
  output logic                       wr_word_o,
  output logic                       wr_pair_r0_o,
  output logic [15:0]                result_o,
  // Status flags
  output logic [5:0]                 flags_o
);
  // All checks below share the core clock and drop out during reset
  default clocking ealu_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ===========================================================
  // Operation classes
  ealu_pkg::ealu_op_t op;
  assign op = op_i;
  wire logic is_add   = (op == ealu_pkg::EALU_ADD) ||
                        (op == ealu_pkg::EALU_ADD_CARRY);
  wire logic is_sub8  = (op == ealu_pkg::EALU_SUB) ||
                        (op == ealu_pkg::EALU_MINUS_IMMEDIATE) ||
                        (op == ealu_pkg::EALU_MINUS_WITH_BORROW) ||
                        (op == ealu_pkg::EALU_MINUS_IMMEDIATE_BORROW);
  wire logic use_c    = (op == ealu_pkg::EALU_ADD_CARRY) ||
                        (op == ealu_pkg::EALU_MINUS_WITH_BORROW) ||
                        (op == ealu_pkg::EALU_MINUS_IMMEDIATE_BORROW);
  wire logic use_imm  = (op == ealu_pkg::EALU_MINUS_IMMEDIATE) ||
                        (op == ealu_pkg::EALU_MINUS_IMMEDIATE_BORROW);
  wire logic is_word  = (op == ealu_pkg::EALU_WORD_PLUS_IMMEDIATE) ||
                        (op == ealu_pkg::EALU_WORD_MINUS_IMMEDIATE);
  wire logic word_sub = (op == ealu_pkg::EALU_WORD_MINUS_IMMEDIATE);
  wire logic is_neg   = (op == ealu_pkg::EALU_TWOS_INVERT_PLUS_ONE);
  wire logic is_inc   = (op == ealu_pkg::EALU_PLUS_ONE_STEP);
  wire logic is_dec   = (op == ealu_pkg::EALU_MINUS_ONE_STEP);
  wire logic is_and   = (op == ealu_pkg::EALU_AND) ||
                        (op == ealu_pkg::EALU_IMMEDIATE_CONJUNCTION);
  wire logic is_frac  = (op == ealu_pkg::EALU_FRACTION_UNSIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_FRACTION_SIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_FRACTION_MIXED_PRODUCT);
  wire logic is_mul   = (op == ealu_pkg::EALU_UNSIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_SIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_MIXED_SIGN_PRODUCT) ||
                        is_frac;
  wire logic a_sgn    = (op == ealu_pkg::EALU_SIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_MIXED_SIGN_PRODUCT) ||
                        (op == ealu_pkg::EALU_FRACTION_SIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_FRACTION_MIXED_PRODUCT);
  wire logic b_sgn    = (op == ealu_pkg::EALU_SIGNED_PRODUCT) ||
                        (op == ealu_pkg::EALU_FRACTION_SIGNED_PRODUCT);
  wire logic two_cyc  = is_word || is_mul;

  // ===========================================================
  // Flag register and its carry
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  wire  logic c_in = flags_q[ealu_pkg::FLAG_C];

  // ===========================================================
  // Byte adder: add, subtract, negate, increment, decrement
  wire logic [7:0] ad_a = is_neg ? ealu_pkg::ALL_ZERO : rd_i;
  wire logic [7:0] ad_b = is_neg ? rd_i :
                          (is_inc || is_dec) ? ealu_pkg::ONE_STEP :
                          use_imm ? imm_i : rr_i;
  wire logic       ad_s = is_sub8 || is_neg || is_dec;
  wire logic       ad_ci = use_c & c_in;
  logic [7:0] ad_sum;
  logic       ad_co;
  logic       ad_h;
  logic       ad_v;
  ealu_adder #(.W(8)) u_byte (
    .a_i    (ad_a),
    .b_i    (ad_b),
    .cin_i  (ad_ci),
    .sub_i  (ad_s),
    .sum_o  (ad_sum),
    .cout_o (ad_co),
    .half_o (ad_h),
    .ovf_o  (ad_v)
  );

  // ===========================================================
  // Word path: pair plus or minus an immediate
  wire logic [15:0] pair   = {rdh_i, rd_i};
  wire logic [16:0] w_full = word_sub ? {1'b0, pair} - {9'h000, imm_i}
                                      : {1'b0, pair} + {9'h000, imm_i};
  wire logic [15:0] w_res  = w_full[15:0];
  wire logic        w_c    = w_full[16];
  wire logic        w_v    = word_sub ? (rdh_i[7] & ~w_res[15])
                                      : (~rdh_i[7] & w_res[15]);

  // ===========================================================
  // Multiplier
  logic [15:0] m_prod;
  logic        m_c;
  ealu_mult u_mult (
    .a_i        (rd_i),
    .b_i        (rr_i),
    .a_signed_i (a_sgn),
    .b_signed_i (b_sgn),
    .frac_i     (is_frac),
    .prod_o     (m_prod),
    .carry_o    (m_c)
  );

  // ===========================================================
  // Logic results and byte result select
  logic [7:0] byte_res;
  always_comb begin
    case (op)
      ealu_pkg::EALU_AND:                   byte_res = rd_i & rr_i;
      ealu_pkg::EALU_IMMEDIATE_CONJUNCTION: byte_res = rd_i & imm_i;
      ealu_pkg::EALU_OR:                    byte_res = rd_i | rr_i;
      ealu_pkg::EALU_IMMEDIATE_UNION:       byte_res = rd_i | imm_i;
      ealu_pkg::EALU_BITWISE_EXCLUSIVE_UNION:
        byte_res = rd_i ^ rr_i;
      ealu_pkg::EALU_BIT_SET_IMMEDIATE:     byte_res = rd_i | imm_i;
      ealu_pkg::EALU_BIT_CLEAR_IMMEDIATE:
        byte_res = rd_i & (ealu_pkg::ALL_ONES - imm_i);
      ealu_pkg::EALU_ZERO_SIGN_CHECK:       byte_res = rd_i & rd_i;
      ealu_pkg::EALU_ONES_INVERT:
        byte_res = ealu_pkg::ALL_ONES - rd_i;
      ealu_pkg::EALU_ZERO_REGISTER:         byte_res = rd_i ^ rd_i;
      ealu_pkg::EALU_ALL_ONES_LOAD:         byte_res = ealu_pkg::ALL_ONES;
      default:                              byte_res = ad_sum;
    endcase
  end

  // ===========================================================
  // Result and flag next values
  wire logic [15:0] res = is_mul  ? m_prod :
                          is_word ? w_res  :
                          {8'h00, byte_res};
  wire logic arith8 = is_add || is_sub8 || is_neg;
  wire logic is_com = (op == ealu_pkg::EALU_ONES_INVERT);
  wire logic is_ser = (op == ealu_pkg::EALU_ALL_ONES_LOAD);
  wire logic n_b    = byte_res[7];
  wire logic v_b    = arith8 ? ad_v : (is_inc || is_dec) ? ad_v : 1'b0;
  always_comb begin
    flags_d = flags_q;
    if (is_mul) begin
      flags_d[ealu_pkg::FLAG_Z] = (m_prod == ealu_pkg::WORD_ZERO);
      flags_d[ealu_pkg::FLAG_C] = m_c;
    end else if (is_word) begin
      flags_d[ealu_pkg::FLAG_Z] = (w_res == ealu_pkg::WORD_ZERO);
      flags_d[ealu_pkg::FLAG_C] = w_c;
      flags_d[ealu_pkg::FLAG_N] = w_res[15];
      flags_d[ealu_pkg::FLAG_V] = w_v;
      flags_d[ealu_pkg::FLAG_S] = w_res[15] ^ w_v;
    end else if (!is_ser) begin
      flags_d[ealu_pkg::FLAG_Z] = (byte_res == ealu_pkg::ALL_ZERO) &&
                                  !(use_c && !flags_q[ealu_pkg::FLAG_Z]
                                    && is_sub8);
      flags_d[ealu_pkg::FLAG_N] = n_b;
      flags_d[ealu_pkg::FLAG_V] = v_b;
      if (arith8) begin
        flags_d[ealu_pkg::FLAG_C] = ad_co;
        flags_d[ealu_pkg::FLAG_H] = ad_h;
      end else if (is_com) begin
        flags_d[ealu_pkg::FLAG_C] = 1'b1;
      end
    end
  end

  // ===========================================================
  // Two-cycle sequencer: first edge holds, second edge retires
  typedef enum logic {EALU_IDLE, EALU_SECOND} ealu_state_t;
  ealu_state_t state_q;
  wire logic take  = start_i && (state_q == EALU_IDLE);
  wire logic retire = (take && !two_cyc) || (state_q == EALU_SECOND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= EALU_IDLE;
    end else begin
      case (state_q)
        EALU_IDLE:   state_q <= (take && two_cyc) ? EALU_SECOND
                                                  : EALU_IDLE;
        EALU_SECOND: state_q <= EALU_IDLE;
        default:     state_q <= EALU_IDLE;
      endcase
    end
  end

  // Latched result of a two-cycle operation, released on the second edge
  logic [15:0] hold_res_q;
  logic [5:0]  hold_flg_q;
  logic        hold_word_q;
  logic        hold_mul_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_res_q  <= ealu_pkg::WORD_ZERO;
      hold_flg_q  <= ealu_pkg::FLAGS_RST;
      hold_word_q <= 1'b0;
      hold_mul_q  <= 1'b0;
    end else if (take) begin
      hold_res_q  <= res;
      hold_flg_q  <= flags_d;
      hold_word_q <= is_word;
      hold_mul_q  <= is_mul;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q      <= ealu_pkg::FLAGS_RST;
      done_o       <= 1'b0;
      busy_o       <= 1'b0;
      wr_en_o      <= 1'b0;
      wr_word_o    <= 1'b0;
      wr_pair_r0_o <= 1'b0;
      result_o     <= ealu_pkg::WORD_ZERO;
    end else begin
      done_o       <= retire && (state_q == EALU_IDLE);
      busy_o       <= take && two_cyc;
      wr_en_o      <= 1'b0;
      wr_word_o    <= 1'b0;
      wr_pair_r0_o <= 1'b0;
      if (state_q == EALU_SECOND) begin
        done_o       <= 1'b1;
        wr_en_o      <= 1'b1;
        wr_word_o    <= hold_word_q;
        wr_pair_r0_o <= hold_mul_q;
        result_o     <= hold_res_q;
        flags_q      <= hold_flg_q;
      end else if (take && !two_cyc) begin
        wr_en_o  <= (op != ealu_pkg::EALU_ZERO_SIGN_CHECK);
        result_o <= res;
        flags_q  <= flags_d;
      end
    end
  end
  assign flags_o = flags_q;

  // ===========================================================
  // Sequencing checks: one-cycle ops retire at once, two-cycle ops
  // hold done low for a cycle so the pair write lands as one word
  one_cycle_done_a: assert property (take && !two_cyc |=> done_o)
    else $error("one-cycle operation did not retire");
  two_cycle_done_a: assert property (
    take && two_cyc |=> !done_o ##1 done_o)
    else $error("two-cycle operation did not retire on its second edge");
  busy_second_a: assert property (take && two_cyc |=> busy_o)
    else $error("busy missing during the second cycle");
  pair_write_a: assert property (
    take && is_mul |=> ##1 wr_en_o && wr_pair_r0_o)
    else $error("product not written to the fixed pair");
  frac_shift_a: assert property (
    take && is_frac |=> ##1 !result_o[0])
    else $error("fractional product not shifted left");

  // Flag checks: each group touches only the flags it owns
  word_sign_a: assert property (
    take && is_word |=> ##1 flags_o[ealu_pkg::FLAG_S] ==
      (flags_o[ealu_pkg::FLAG_N] ^ flags_o[ealu_pkg::FLAG_V]))
    else $error("word sign flag is not N xor V");
  step_carry_a: assert property (
    take && (is_inc || is_dec) |=>
      $stable(flags_o[ealu_pkg::FLAG_C]))
    else $error("increment or decrement changed carry");
  ones_load_a: assert property (
    take && is_ser |=> $stable(flags_o) &&
      result_o == {8'h00, ealu_pkg::ALL_ONES})
    else $error("all-ones load changed flags or missed its value");
  and_clear_v_a: assert property (
    take && is_and |=> !flags_o[ealu_pkg::FLAG_V])
    else $error("conjunction left overflow set");
  ones_carry_a: assert property (
    take && is_com |=> flags_o[ealu_pkg::FLAG_C])
    else $error("ones complement did not set carry");

  // Main scenarios worth seeing at least once
  mul_retire_c: cover property (take && is_mul ##2 done_o);
  word_sub_c: cover property (take && word_sub ##2 done_o);
  borrow_chain_c: cover property (
    take && use_c && is_sub8 && flags_q[ealu_pkg::FLAG_C]);
  sticky_zero_c: cover property (
    take && use_c && is_sub8 && flags_q[ealu_pkg::FLAG_Z]);
endmodule

// file: test/ealu_core_bench.sv
// Self-checking bench for the 8-bit ALU core against an integer model
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: op %0d got %h exp %h", $time, cur, g, e); end end
module ealu_core_bench;
  // ==========================================================
  // Stimulus and observation signals
  localparam int FC = ealu_pkg::FLAG_C;
  localparam int FZ = ealu_pkg::FLAG_Z;
  localparam int FN = ealu_pkg::FLAG_N;
  localparam int FV = ealu_pkg::FLAG_V;
  localparam int FS = ealu_pkg::FLAG_S;
  localparam int FH = ealu_pkg::FLAG_H;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               start_i = 1'b0;
  ealu_pkg::ealu_op_t op_i = ealu_pkg::EALU_ADD;
  logic [7:0]         rd_i = 8'h00;
  logic [7:0]         rdh_i = 8'h00;
  logic [7:0]         rr_i = 8'h00;
  logic [7:0]         imm_i = 8'h00;
  logic               done_o, busy_o, wr_en_o, wr_word_o, wr_pair_r0_o;
  logic [15:0]        result_o;
  logic [5:0]         flags_o;
  logic [15:0]        m_res;
  logic [5:0]         mf;
  int                 mismatches = 0;
  int                 comparisons = 0;
  int                 cur;

  // Half-period toggle gives the 25 MHz core clock
  always #20 clk_i = ~clk_i;

  ealu_core u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
    .rd_i(rd_i), .rdh_i(rdh_i), .rr_i(rr_i), .imm_i(imm_i),
    .done_o(done_o), .busy_o(busy_o), .wr_en_o(wr_en_o),
    .wr_word_o(wr_word_o), .wr_pair_r0_o(wr_pair_r0_o),
    .result_o(result_o), .flags_o(flags_o));

  // ==========================================================
  // Model helpers; each touches only the flags its group owns
  task automatic zn(input int res);
    m_res = 16'(res & 255);
    mf[FZ] = (res & 255) == 0;
    mf[FN] = res[7];
  endtask
  task automatic logic_op(input int res);
    zn(res);
    mf[FV] = 1'b0;
  endtask
  task automatic arith(input int a, b, c, input bit sub);
    int s, r;
    s = sub ? a - b - c : a + b + c;
    r = s & 255;
    zn(r);
    mf[FC] = sub ? s < 0 : s > 255;
    mf[FH] = sub ? (a & 15) - (b & 15) - c < 0 : (a & 15) + (b & 15) + c > 15;
    mf[FV] = sub ? ((a ^ b) & (a ^ r) & 128) != 0
                 : (~(a ^ b) & (a ^ r) & 128) != 0;
  endtask
  task automatic word(input int a, k, input bit sub);
    int s, r;
    s = sub ? a - k : a + k;
    r = s & 16'hffff;
    m_res = 16'(r);
    mf[FZ] = r == 0;
    mf[FN] = r[15];
    mf[FC] = sub ? s < 0 : s > 16'hffff;
    mf[FV] = sub ? a[15] & ~r[15] : ~a[15] & r[15];
    mf[FS] = mf[FN] ^ mf[FV];
  endtask
  task automatic product(input int d, r, input bit sa, sb, fr);
    int a, b, p;
    a = (sa && d > 127) ? d - 256 : d;
    b = (sb && r > 127) ? r - 256 : r;
    p = (a * b) & 16'hffff;
    mf[FC] = p[15];
    if (fr) p = (p << 1) & 16'hffff;
    m_res = 16'(p);
    mf[FZ] = p == 0;
  endtask

  // Expected result and flags for one operation
  task automatic model(input int op, d, h, r, k);
    bit z;
    z = mf[FZ];
    case (op)
      0: arith(d, r, 0, 0);
      1: arith(d, r, int'(mf[FC]), 0);
      2: word(h * 256 + d, k, 0);
      3: arith(d, r, 0, 1);
      4: arith(d, k, 0, 1);
      5: arith(d, r, int'(mf[FC]), 1);
      6: arith(d, k, int'(mf[FC]), 1);
      7: word(h * 256 + d, k, 1);
      8: logic_op(d & r);
      9: logic_op(d & k);
      10: logic_op(d | r);
      11, 15: logic_op(d | k);
      12: logic_op(d ^ r);
      13: begin logic_op(255 - d); mf[FC] = 1'b1; end
      14: arith(0, d, 0, 1);
      16: logic_op(d & (255 - k));
      17: begin zn(d + 1); mf[FV] = d == 127; end
      18: begin zn(d + 255); mf[FV] = d == 128; end
      19: logic_op(d);
      20: logic_op(0);
      21: m_res = 16'h00ff;
      default: product(d, r, op inside {23, 24, 26, 27}, op inside {23, 26},
                       op >= 25);
    endcase
    // A borrow chain keeps zero only while every byte so far was zero
    if (op == 5 || op == 6) mf[FZ] = mf[FZ] & z;
  endtask

  // ==========================================================
  // One request: raise start for one cycle, wait for done, check
  task automatic run_op(input int op, d, h, r, k);
    int n;
    bit dbl;
    dbl = op inside {2, 7, [22:27]};
    cur = op;
    op_i = ealu_pkg::ealu_op_t'(op);
    rd_i = 8'(d);
    rdh_i = 8'(h);
    rr_i = 8'(r);
    imm_i = 8'(k);
    start_i = 1'b1;
    model(op, d, h, r, k);
    n = 0;
    do begin
      @(posedge clk_i);
      #2;
      start_i = 1'b0;
      n++;
      if (n == 1) `CHK(busy_o, dbl)
    end while (done_o !== 1'b1 && n < 8);
    `CHK(n, dbl ? ealu_pkg::CYC_DOUBLE : ealu_pkg::CYC_SINGLE)
    if (op >= 22) `CHK(result_o, m_res)
    else if (dbl) `CHK(result_o, m_res)
    else `CHK(result_o[7:0], m_res[7:0])
    `CHK(wr_pair_r0_o, op >= 22)
    `CHK(wr_en_o, op != 19)
    `CHK(wr_word_o, op == 2 || op == 7)
    // Flags are looked at one idle cycle later, settled either way
    @(posedge clk_i);
    #2;
    `CHK(flags_o, mf)
  endtask

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches",
             comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Every operation code with corner operands first, then random
  initial begin
    int d, r;
    void'($urandom(32'hc4fe));
    mf = ealu_pkg::FLAGS_RST;
    repeat (8) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    `CHK(flags_o, mf)
    for (int j = 0; j < 8; j++) begin
      for (int op = 0; op < 28; op++) begin
        d = j == 0 ? 255 : j == 1 ? 128 : j == 2 ? 0 : $urandom % 256;
        r = j == 0 ? 1 : j == 1 ? 128 : j == 2 ? 0 : $urandom % 256;
        run_op(op, d, j == 0 ? 255 : $urandom % 256, r, $urandom % 64);
      end
      $display("test pass %0d done", j);
    end
    close_out();
  end

  // Watchdog well beyond 224 operations of a few cycles each
  initial begin
    #(40 * 20000);
    mismatches++;
    close_out();
  end
endmodule
